// file: src/sac_top.sv
// Conversion control of a 10-bit successive approximation converter
//
// Local design decisions: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module sac_top #(
    parameter int NUM_TRIG = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [NUM_TRIG-1:0] trig_in,
    input wire logic done_irq_ack,
    input wire logic [9:0] analog_result,
    output logic [3:0] active_channel,
    output logic [2:0] active_reference,
    output logic amp_bypass,
    output logic diff_pos_sel,
    output logic [1:0] diff_neg_sel,
    output logic gain_20x,
    output logic temp_sensor_sel,
    output logic analog_on,
    output logic sample_now,
    output logic converting,
    output logic done_irq
);
    // ****************************************
    // Reset synchroniser
    // ****************************************
    logic rst_meta;
    logic rst_n;

    // Release is synchronised, assertion is immediate
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ****************************************
    // Analog result synchroniser
    // ****************************************
    logic [9:0] res_meta;
    logic [9:0] res_sync;

    // Result comes from the analog side, another timing domain
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            res_meta <= '0;
            res_sync <= '0;
        end else begin
            res_meta <= analog_result;
            res_sync <= res_meta;
        end
    end

    // ****************************************
    // Bus slave handshake
    // ****************************************
    logic bus_req;
    logic bus_acc;
    logic wr_acc;
    logic rd_acc;

    assign bus_req = avs_read | avs_write;
    assign bus_acc = bus_req & ~avs_waitrequest;
    assign wr_acc = avs_write & ~avs_waitrequest;
    assign rd_acc = avs_read & ~avs_waitrequest;

    // One wait cycle per access, then the access completes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= ~(bus_req & avs_waitrequest);
        end
    end

    // ****************************************
    // Configuration registers
    // ****************************************
    logic enable;
    logic auto_trigger_enable;
    logic [2:0] prescale_sel;
    logic [2:0] trigger_source_select;
    logic [3:0] channel_select_field;
    logic [2:0] reference_select_field;
    logic left_align_result;
    logic wr_ctrl_a;

    assign wr_ctrl_a = wr_acc && (avs_address == sac_pkg::ADDR_CTRL_A);

    // Plain read/write configuration bits
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enable <= sac_pkg::CTRL_A_RST[sac_pkg::CA_ENABLE];
            auto_trigger_enable <= sac_pkg::CTRL_A_RST[sac_pkg::CA_AUTO];
            prescale_sel <= sac_pkg::CTRL_A_RST[2:0];
            trigger_source_select <= sac_pkg::CTRL_B_RST[2:0];
            channel_select_field <= sac_pkg::INSEL_RST[3:0];
            left_align_result <= sac_pkg::INSEL_RST[sac_pkg::IS_LEFT];
            reference_select_field <= sac_pkg::INSEL_RST[8:6];
        end else if (wr_acc) begin
            unique case (avs_address)
                sac_pkg::ADDR_CTRL_A: begin
                    enable <= avs_writedata[sac_pkg::CA_ENABLE];
                    auto_trigger_enable <= avs_writedata[sac_pkg::CA_AUTO];
                    prescale_sel <= avs_writedata[sac_pkg::CA_PSEL_LO +: 3];
                end
                sac_pkg::ADDR_CTRL_B: begin
                    trigger_source_select <=
                        avs_writedata[sac_pkg::CB_TSEL_LO +: 3];
                end
                sac_pkg::ADDR_INSEL: begin
                    channel_select_field <= avs_writedata[sac_pkg::IS_CH_LO +: 4];
                    left_align_result <= avs_writedata[sac_pkg::IS_LEFT];
                    reference_select_field <=
                        avs_writedata[sac_pkg::IS_REF_LO +: 3];
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // Prescaler
    // ****************************************
    logic conv_tick;
    logic trig_edge;

    sac_prescaler #(
        .DIV_W(sac_pkg::DIV_W)
    ) u_presc (
        .clk(clk),
        .rst_n(rst_n),
        .run(enable),
        .restart(trig_edge),
        .div_sel(prescale_sel),
        .tick(conv_tick)
    );

    // ****************************************
    // Trigger edge detection
    // ****************************************
    sac_pkg::sac_state_t state;
    logic trig_sel;
    logic trig_prev;
    logic conv_end;
    logic free_run;

    // On-chip triggers share this clock, so no synchroniser
    assign trig_sel = trig_in[trigger_source_select];
    assign free_run = auto_trigger_enable &&
        (trigger_source_select == sac_pkg::TSEL_FREE);

    // Previous level is tracked always, so a level held high never retriggers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trig_prev <= 1'b0;
        end else begin
            trig_prev <= trig_sel;
        end
    end

    // Edges count only when enabled, auto mode, and the converter idle
    assign trig_edge = enable && auto_trigger_enable && !free_run &&
        trig_sel && !trig_prev &&
        (state == sac_pkg::SAC_IDLE);

    // ****************************************
    // Conversion sequencer
    // ****************************************
    logic start_bit;
    logic sw_start;
    logic first_conv;
    logic [4:0] cyc_cnt;
    logic [4:0] cyc_len;

    assign sw_start = wr_ctrl_a && avs_writedata[sac_pkg::CA_START] &&
        avs_writedata[sac_pkg::CA_ENABLE];
    assign cyc_len = first_conv ? sac_pkg::CYC_FIRST : sac_pkg::CYC_NORMAL;
    assign conv_end = (state == sac_pkg::SAC_CONV) && conv_tick &&
        (cyc_cnt == cyc_len - 5'h01);

    // Waits for the next converter clock edge, then counts cycles
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= sac_pkg::SAC_IDLE;
            cyc_cnt <= '0;
        end else if (!enable) begin
            state <= sac_pkg::SAC_IDLE;
            cyc_cnt <= '0;
        end else begin
            unique case (state)
                sac_pkg::SAC_IDLE: begin
                    if (sw_start || trig_edge) begin
                        state <= sac_pkg::SAC_WAIT;
                    end
                end
                sac_pkg::SAC_WAIT: begin
                    cyc_cnt <= '0;
                    if (conv_tick) begin
                        state <= sac_pkg::SAC_CONV;
                    end
                end
                sac_pkg::SAC_CONV: begin
                    if (conv_end) begin
                        cyc_cnt <= '0;
                        // Free running chains straight into the next one
                        if (free_run) begin
                            state <= sac_pkg::SAC_CONV;
                        end else begin
                            state <= sac_pkg::SAC_IDLE;
                        end
                    end else if (conv_tick) begin
                        cyc_cnt <= cyc_cnt + 5'h01;
                    end
                end
                default: begin
                    state <= sac_pkg::SAC_IDLE;
                end
            endcase
        end
    end

    // First conversion after enabling needs the long initialisation
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            first_conv <= 1'b1;
        end else if (!enable) begin
            first_conv <= 1'b1;
        end else if (conv_end) begin
            first_conv <= 1'b0;
        end
    end

    // Start bit mirrors any running or pending conversion
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            start_bit <= 1'b0;
        end else if (!enable) begin
            start_bit <= 1'b0;
        end else if (sw_start || trig_edge) begin
            start_bit <= 1'b1;
        end else if (conv_end && !free_run) begin
            start_bit <= 1'b0;
        end
    end

    // ****************************************
    // Completion flag
    // ****************************************
    logic done_flag;
    logic done_clr;

    assign done_clr = (wr_ctrl_a && avs_writedata[sac_pkg::CA_DONE]) ||
        done_irq_ack;

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            done_flag <= 1'b0;
        end else if (conv_end) begin
            done_flag <= 1'b1;
        end else if (done_clr) begin
            done_flag <= 1'b0;
        end
    end

    // ****************************************
    // Result registers with read-order lock
    // ****************************************
    logic [7:0] result_low_byte;
    logic [7:0] result_high_byte;
    logic res_locked;
    logic rd_lo;
    logic rd_hi;

    assign rd_lo = rd_acc && (avs_address == sac_pkg::ADDR_RES_LO);
    assign rd_hi = rd_acc && (avs_address == sac_pkg::ADDR_RES_HI);

    // Low byte read locks, high byte read unlocks
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            res_locked <= 1'b0;
        end else if (rd_hi) begin
            res_locked <= 1'b0;
        end else if (rd_lo) begin
            res_locked <= 1'b1;
        end
    end

    // Result lands with alignment chosen at completion time
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result_low_byte <= '0;
            result_high_byte <= '0;
        end else if (conv_end && !res_locked) begin
            if (left_align_result) begin
                result_high_byte <= res_sync[9:2];
                result_low_byte <= {res_sync[1:0], 6'h00};
            end else begin
                result_high_byte <= {6'h00, res_sync[9:8]};
                result_low_byte <= res_sync[7:0];
            end
        end
    end

    // ****************************************
    // Locked analog selection
    // ****************************************
    logic sel_update;

    // Selection follows the register only while enabled and not converting;
    // it reopens in the last cycle so the next conversion sees new values
    assign sel_update = enable && ((state == sac_pkg::SAC_IDLE) ||
        (state == sac_pkg::SAC_CONV && cyc_cnt == cyc_len - 5'h01));

    // Active selection drives the analog multiplexer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active_channel <= '0;
            active_reference <= '0;
            amp_bypass <= 1'b1;
            diff_pos_sel <= 1'b0;
            diff_neg_sel <= '0;
            gain_20x <= 1'b0;
            temp_sensor_sel <= 1'b0;
        end else if (sel_update) begin
            active_channel <= channel_select_field;
            active_reference <= reference_select_field;
            amp_bypass <= (channel_select_field <= sac_pkg::CH_SE_MAX) ||
                (channel_select_field == sac_pkg::CH_TEMP);
            diff_pos_sel <= channel_select_field[3];
            diff_neg_sel <= channel_select_field[2:1];
            gain_20x <= (channel_select_field > sac_pkg::CH_SE_MAX) &&
                (channel_select_field != sac_pkg::CH_TEMP) &&
                channel_select_field[0];
            temp_sensor_sel <=
                (channel_select_field == sac_pkg::CH_TEMP);
        end
    end

    // ****************************************
    // Status outputs
    // ****************************************
    // Sample pulse at the first converter cycle of a conversion started from idle; chained free-running ones get none
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            analog_on <= 1'b0;
            sample_now <= 1'b0;
            converting <= 1'b0;
            done_irq <= 1'b0;
        end else begin
            analog_on <= enable;
            sample_now <= (state == sac_pkg::SAC_WAIT) && conv_tick;
            converting <= (state != sac_pkg::SAC_IDLE);
            done_irq <= conv_end || (done_flag && !done_clr);
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    // Loaded during the wait cycle so data stands when waitrequest drops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= '0;
        end else if (avs_read && avs_waitrequest) begin
            unique case (avs_address)
                sac_pkg::ADDR_CTRL_A:
                    avs_readdata <= {24'h000000, enable, start_bit,
                        auto_trigger_enable, done_flag, 1'b0,
                        prescale_sel};
                sac_pkg::ADDR_CTRL_B:
                    avs_readdata <= {29'h00000000, trigger_source_select};
                sac_pkg::ADDR_INSEL:
                    avs_readdata <= {23'h000000, reference_select_field,
                        left_align_result, 1'b0, channel_select_field};
                sac_pkg::ADDR_RES_LO:
                    avs_readdata <= {24'h000000, result_low_byte};
                sac_pkg::ADDR_RES_HI:
                    avs_readdata <= {24'h000000, result_high_byte};
                default:
                    avs_readdata <= 32'h00000000;
            endcase
        end
    end
endmodule

// file: inc/sac_pkg.sv
// Package of constants for the converter control block
package sac_pkg;
    // ****************************************
    // Register word indices
    // ****************************************
    localparam logic [2:0] ADDR_CTRL_A = 3'h0;
    localparam logic [2:0] ADDR_CTRL_B = 3'h1;
    localparam logic [2:0] ADDR_INSEL = 3'h2;
    localparam logic [2:0] ADDR_RES_LO = 3'h3;
    localparam logic [2:0] ADDR_RES_HI = 3'h4;

    // ****************************************
    // Control A fields
    // ****************************************
    localparam int CA_ENABLE = 7;
    localparam int CA_START = 6;
    localparam int CA_AUTO = 5;
    localparam int CA_DONE = 4;
    localparam int CA_PSEL_LO = 0;
    localparam int PSEL_W = 3;

    // ****************************************
    // Control B and input select fields
    // ****************************************
    localparam int CB_TSEL_LO = 0;
    localparam int TSEL_W = 3;
    localparam int IS_CH_LO = 0;
    localparam int CH_W = 4;
    localparam int IS_LEFT = 5;
    localparam int IS_REF_LO = 6;
    localparam int REF_W = 3;

    // ****************************************
    // Reset values and encodings
    // ****************************************
    localparam logic [7:0] CTRL_A_RST = 8'h00;
    localparam logic [7:0] CTRL_B_RST = 8'h00;
    localparam logic [8:0] INSEL_RST = 9'h000;
    localparam logic [2:0] TSEL_FREE = 3'h0;
    localparam logic [3:0] CH_TEMP = 4'hF;
    localparam logic [3:0] CH_SE_MAX = 4'h3;

    // ****************************************
    // Timing in converter clock cycles, result and divider widths, sequencer states
    // ****************************************
    localparam logic [4:0] CYC_NORMAL = 5'h0D;
    localparam logic [4:0] CYC_FIRST = 5'h19;
    localparam int RES_W = 10;
    localparam int DIV_W = 7;

    typedef enum logic [1:0] {
        SAC_IDLE = 2'b00,
        SAC_WAIT = 2'b01,
        SAC_CONV = 2'b10
    } sac_state_t;
endpackage

// file: src/sac_prescaler.sv
// Converter clock prescaler producing one tick per converter clock cycle
`timescale 1ns/1ps
module sac_prescaler #(
    parameter int DIV_W = 7
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic restart,
    input wire logic [2:0] div_sel,
    output logic tick
);
    logic [DIV_W-1:0] cnt;
    logic [DIV_W-1:0] limit;

    // Division by 2 to the power of the select, never below 2
    always_comb begin
        if (div_sel == 3'h0) begin
            limit = DIV_W'(1);
        end else begin
            limit = DIV_W'((8'h01 << div_sel) - 8'h01);
        end
    end

    // Held cleared while disabled, restarted by a trigger
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
            tick <= 1'b0;
        end else if (!run || restart) begin
            cnt <= '0;
            tick <= 1'b0;
        end else if (cnt >= limit) begin
            cnt <= '0;
            tick <= 1'b1;
        end else begin
            cnt <= cnt + DIV_W'(1);
            tick <= 1'b0;
        end
    end
endmodule

// file: verif/sac_asserts.sv
// Concurrent checks on the converter control ports, bound to the top
`timescale 1ns/1ps
module sac_checker (
    input wire logic clk,
    input wire logic resetn,
    input wire logic done_irq_ack,
    input wire logic [3:0] active_channel,
    input wire logic [2:0] active_reference,
    input wire logic amp_bypass,
    input wire logic gain_20x,
    input wire logic temp_sensor_sel,
    input wire logic analog_on,
    input wire logic sample_now,
    input wire logic converting,
    input wire logic done_irq
);
    // One clock domain, so one clocking and one disable for all checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // Conversion timing and the completion flag
    sample_conv_a: assert property (
        sample_now |-> converting ##1 !sample_now)
        else $error("sample pulse outside a conversion");
    chan_lock_a: assert property (
        sample_now |=>
        ($stable(active_channel) && $stable(active_reference))[*8])
        else $error("selection moved during conversion");
    done_cause_a: assert property (
        $rose(done_irq) |-> $past(converting))
        else $error("done flag without a conversion");
    done_clear_a: assert property (
        done_irq && done_irq_ack && !converting |-> ##[1:2] !done_irq)
        else $error("done flag not cleared by service");

    // Channel decode, checked once the applied channel has settled
    se_bypass_a: assert property (
        active_channel <= 4'h3 && $stable(active_channel) |-> amp_bypass)
        else $error("single ended not bypassed");
    diff_gain_a: assert property (
        active_channel inside {[4'h4:4'hE]} && $stable(active_channel)
        |-> !amp_bypass && gain_20x == active_channel[0])
        else $error("differential decode wrong");
    temp_sel_a: assert property (
        active_channel == 4'hF && $stable(active_channel)
        |-> temp_sensor_sel)
        else $error("temperature sensor not routed");
    // Lag of one cycle allowed, as enable and selection register together
    off_hold_a: assert property (
        !analog_on ##1 !analog_on |-> $stable(active_channel))
        else $error("selection applied while disabled");
endmodule

bind sac_top sac_checker u_chk (
    .clk(clk),
    .resetn(resetn),
    .done_irq_ack(done_irq_ack),
    .active_channel(active_channel),
    .active_reference(active_reference),
    .amp_bypass(amp_bypass),
    .gain_20x(gain_20x),
    .temp_sensor_sel(temp_sensor_sel),
    .analog_on(analog_on),
    .sample_now(sample_now),
    .converting(converting),
    .done_irq(done_irq)
);

// file: verif/sac_trig_model.sv
// Trigger sources: interrupt style flags that software must clear
`timescale 1ns/1ps
module sac_trig_model (
    input wire logic clk,
    input wire logic [7:0] event_in,
    input wire logic [7:0] flag_clear,
    output logic [7:0] trig_in
);
    logic [7:0] flags = 8'h00;

    // One driver for the flags, the port only mirrors them
    assign trig_in = flags;

    // Flag sets whatever the enables; a clear wins so no edge is faked
    always @(posedge clk) begin
        flags <= (flags | event_in) & ~flag_clear;
    end
endmodule

// file: verif/sac_top_tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
    $display("mismatch %s exp %0h got %0h", n, e, g); end end
module sac_top_tb_top;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [2:0] avs_address = 3'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [7:0] trig_in;
    logic [7:0] trig_event = 8'h00;
    logic [7:0] trig_clear = 8'h00;
    logic done_irq_ack = 1'b0;
    logic [9:0] analog_result = 10'h000;
    logic [3:0] active_channel;
    logic [2:0] active_reference;
    logic [1:0] diff_neg_sel;
    logic amp_bypass, diff_pos_sel, gain_20x, temp_sensor_sel;
    logic analog_on, sample_now, converting, done_irq;
    logic [31:0] q;
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;
    int m_lo = 0;
    int m_hi = 0;
    int m_lock = 0;
    int m_left = 0;
    int m_first = 1;
    int busy_cyc = 0;
    int exp_c = 0;

    always #25 clk = ~clk;

    sac_top dut (.clk(clk), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .trig_in(trig_in),
        .done_irq_ack(done_irq_ack), .analog_result(analog_result),
        .active_channel(active_channel), .active_reference(active_reference),
        .amp_bypass(amp_bypass), .diff_pos_sel(diff_pos_sel),
        .diff_neg_sel(diff_neg_sel), .gain_20x(gain_20x),
        .temp_sensor_sel(temp_sensor_sel), .analog_on(analog_on),
        .sample_now(sample_now), .converting(converting),
        .done_irq(done_irq));
    sac_trig_model u_trig (.clk(clk), .event_in(trig_event),
        .flag_clear(trig_clear), .trig_in(trig_in));

    // Avalon master: hold the request until waitrequest is seen low
    task bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 40) failures++;
    endtask

    // Poll the start bit as software would; bounded so a hang shows
    task wait_idle;
        int k;
        k = 0;
        q = 32'h40;
        while (q[6] && k < 100) begin
            bus(1'b0, sac_pkg::ADDR_CTRL_A, 32'h0);
            k++;
        end
    endtask

    // Start one conversion, optionally reselect mid-way, update the model
    task conv(input logic [9:0] r, input logic [7:0] ca, input int sel);
        busy_cyc = 0;
        analog_result <= r;
        bus(1'b1, sac_pkg::ADDR_CTRL_A, 32'(ca));
        if (sel >= 0) begin
            bus(1'b1, sac_pkg::ADDR_INSEL, sel);
            `CHK("chan_hold", 4'h0, active_channel)
        end
        wait_idle();
        // Divide by 2; up to two clocks spent waiting for the first tick
        exp_c = m_first ? 2 * sac_pkg::CYC_FIRST : 2 * sac_pkg::CYC_NORMAL;
        m_first = 0;
        `CHK("conv_len", 1'b1, (busy_cyc - exp_c) inside {1, 2})
        `CHK("start_clr", 1'b0, q[6])
        `CHK("done_set", 1'b1, q[4])
        if (m_lock == 0) begin
            m_hi = m_left ? r >> 2 : r >> 8;
            m_lo = m_left ? (r & 3) << 6 : r & 8'hFF;
        end
    endtask

    // Low byte first locks the pair, high byte unlocks it
    task rd_res;
        bus(1'b0, sac_pkg::ADDR_RES_LO, 32'h0);
        m_lock = 1;
        `CHK("res_lo", m_lo[7:0], q[7:0])
        bus(1'b0, sac_pkg::ADDR_RES_HI, 32'h0);
        m_lock = 0;
        `CHK("res_hi", m_hi[7:0], q[7:0])
    endtask

    // Pulse a flag clear or a flag event for one cycle
    task fire(input logic [7:0] clr, input logic [7:0] ev);
        @(posedge clk);
        trig_clear <= clr;
        trig_event <= ev;
        @(posedge clk);
        trig_clear <= 8'h00;
        trig_event <= 8'h00;
    endtask

    task report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Cycle ceiling well above the expected several hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (converting === 1'b1) busy_cyc++;
        if (cycles == 20000) begin
            failures++;
            report_and_stop();
        end
    end

    // Main sequence
    initial begin
        void'($urandom(32'hEAC0));
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        bus(1'b0, sac_pkg::ADDR_CTRL_A, 32'h0);
        `CHK("ctrl_a_rst", sac_pkg::CTRL_A_RST, q[7:0])
        bus(1'b0, sac_pkg::ADDR_INSEL, 32'h0);
        `CHK("insel_rst", sac_pkg::INSEL_RST, q[8:0])
        bus(1'b1, 3'h5, 32'hFF);
        bus(1'b0, 3'h5, 32'h0);
        `CHK("unmapped", 32'h0, q)
        bus(1'b1, sac_pkg::ADDR_INSEL, 32'h45);
        repeat (4) @(posedge clk);
        `CHK("chan_off", 4'h0, active_channel)
        bus(1'b1, sac_pkg::ADDR_CTRL_A, 32'h80);
        for (int i = 0; i < 16; i++) begin
            bus(1'b1, sac_pkg::ADDR_INSEL, 32'({i[2:0], 2'b00, i[3:0]}));
            repeat (3) @(posedge clk);
            `CHK("chan", i[3:0], active_channel)
            `CHK("ref", i[2:0], active_reference)
            `CHK("bypass", i < 4 || i == 15, amp_bypass)
            `CHK("diff", i[3:1], {diff_pos_sel, diff_neg_sel})
            `CHK("gain", i > 3 && i < 15 && i[0], gain_20x)
            `CHK("temp", i == 15, temp_sensor_sel)
        end
        bus(1'b1, sac_pkg::ADDR_INSEL, 32'h0);
        conv(10'($urandom), 8'hD0, -1);
        rd_res();
        bus(1'b1, sac_pkg::ADDR_INSEL, 32'h20);
        m_left = 1;
        conv(10'($urandom), 8'hD0, -1);
        rd_res();
        bus(1'b0, sac_pkg::ADDR_RES_LO, 32'h0);
        m_lock = 1;
        `CHK("lock_lo", m_lo[7:0], q[7:0])
        conv(10'($urandom), 8'hD0, 32'h22);
        `CHK("new_chan", 4'h2, active_channel)
        bus(1'b0, sac_pkg::ADDR_RES_HI, 32'h0);
        m_lock = 0;
        `CHK("lock_hi", m_hi[7:0], q[7:0])
        conv(10'($urandom), 8'hD0, -1);
        rd_res();
        bus(1'b1, sac_pkg::ADDR_CTRL_B, 32'h3);
        bus(1'b1, sac_pkg::ADDR_CTRL_A, 32'hB0);
        fire(8'h00, 8'h08);
        repeat (6) @(posedge clk);
        `CHK("trig_start", 1'b1, converting)
        bus(1'b0, sac_pkg::ADDR_CTRL_A, 32'h0);
        `CHK("busy_bit", 1'b1, q[6])
        fire(8'h08, 8'h00);
        fire(8'h00, 8'h08);
        wait_idle();
        repeat (60) @(posedge clk);
        `CHK("no_retrig", 1'b0, converting)
        fire(8'h08, 8'h00);
        fire(8'h00, 8'h08);
        repeat (6) @(posedge clk);
        `CHK("flag_retrig", 1'b1, converting)
        wait_idle();
        conv(10'($urandom), 8'hF0, -1);
        rd_res();
        `CHK("irq_set", 1'b1, done_irq)
        @(posedge clk);
        done_irq_ack <= 1'b1;
        @(posedge clk);
        done_irq_ack <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK("ack_clear", 1'b0, done_irq)
        bus(1'b1, sac_pkg::ADDR_CTRL_B, 32'h0);
        bus(1'b1, sac_pkg::ADDR_CTRL_A, 32'hF0);
        repeat (150) @(posedge clk);
        bus(1'b0, sac_pkg::ADDR_CTRL_A, 32'h0);
        `CHK("free_busy", 1'b1, q[6])
        `CHK("free_run", 1'b1, converting)
        bus(1'b1, sac_pkg::ADDR_CTRL_A, 32'h0);
        repeat (4) @(posedge clk);
        `CHK("off_conv", 1'b0, converting)
        `CHK("off_analog", 1'b0, analog_on)
        report_and_stop();
    end
endmodule
